/* rtl/stc_pkg.sv */
// Package with register map, field layout and bus carriers for the timer.
// Operation
// - 16-bit counter, timer or external counter
// - Wide mode: whole count coherent across two byte accesses
// - Narrow mode: two independent byte halves
// - Prescale 10 divides four, 01 two
// - Bit 3 routes this count to capture
// - Bit 2 bypasses external clock alignment flop
// - Internal clock ignores the bypass bit
// - External rising edge after first falling
// - Source clear counts the instruction clock
// - Run bit counts; clear holds value
// - Control bit 6 reads zero
// - Special event trigger clears the count unless bypassed
// - Control register resets to zero
// - Wide low read buffers high byte
// - Wide high write buffered, loads on low
// - Rollover sets flag; enable gates interrupt
// - Count write beats trigger reset
package stc_pkg;
    localparam int ADDR_W = 4;
    localparam int PRESCALE_W = 3;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] LOW_OFS  = 4'h4;
    localparam logic [ADDR_W-1:0] HIGH_OFS = 4'h8;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'hc;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hbf;
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_IEN_BIT  = 1;

    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV2 = 2'h1;
    localparam logic [1:0] PS_DIV4 = 2'h2;
    localparam logic [1:0] PS_DIV8 = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       wideAccessMode;
        logic       unused6;
        logic [1:0] prescaleSelect;
        logic       captureTimebaseSelect;
        logic       extClockSyncBypass;
        logic       clockSourceSelect;
        logic       counterRun;
    } stc_ctrl_s;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } stc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } stc_axi_rsp_s;
endpackage : stc_pkg

/* rtl/stc_prescaler.sv */
// Prescaler dividing the count source by one, two, four or eight.
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler
    import stc_pkg::*;
#(
    parameter int W = PRESCALE_W
) (
    input  wire logic       sys_clk,  // System clock.
    input  wire logic       nrst,     // Asynchronous reset, active low.
    input  wire logic       clkEn,    // Freezes state while low.
    input  wire logic       clear,    // Restarts the division.
    input  wire logic       tickIn,   // Source pulse.
    input  wire logic [1:0] sel,      // Division select.
    output var  logic       tickOut   // Divided pulse.
);
    logic [W-1:0] stage;
    logic [W-1:0] mask;

    assign mask = (sel == PS_DIV2) ? W'(1) :
                  (sel == PS_DIV4) ? W'(3) :
                  (sel == PS_DIV8) ? W'(7) : W'(0);

    assign tickOut = tickIn & ((stage & mask) == mask);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stage <= '0;
        end else if (clkEn) begin
            if (clear) begin
                stage <= '0;
            end else if (tickIn) begin
                stage <= stage + W'(1);
            end
        end
    end

    chk_div_four: assert property (@(posedge sys_clk) disable iff (!nrst)
        clkEn && !clear && tickIn && sel == PS_DIV4 && stage[1:0] != 2'h3
        |-> !tickOut) else $error("divide by four pulsed early");
endmodule : stc_prescaler
`default_nettype wire

/* rtl/stc_timer_counter.sv */
// Sixteen-bit timer/counter with AXI4-Lite register access.
`timescale 1ns/1ps
`default_nettype none
module stc_timer_counter
    import stc_pkg::*;
(
    input  wire logic         sys_clk,         // Instruction clock.
    input  wire logic         nrst,            // Async reset, active low.
    input  wire logic         clkEn,           // Freezes all state when low.
    input  wire stc_axi_req_s busReq,          // AXI4-Lite master side.
    output var  stc_axi_rsp_s busRsp,          // AXI4-Lite slave side.
    input  wire logic         extClockPin,     // External count pin.
    input  wire logic         companionOsc,    // Companion oscillator.
    input  wire logic         companionOscEn,  // Use oscillator, not pin.
    input  wire logic [15:0]  companionCount,  // Companion timer count.
    input  wire logic         specialTrigger,  // Event trigger from capture.
    output var  logic [15:0]  ccpTimeBase,     // Time base for capture.
    output var  logic         overflowIrq      // Gated overflow interrupt.
);
    stc_ctrl_s         ctrl;
    stc_ctrl_s         next_ctrl;
    logic [15:0]       count;
    logic [15:0]       next_count;
    logic [7:0]        highBuf;
    logic              ovfFlag;
    logic              ovfIrqEn;
    logic              next_ovfFlag;
    logic              next_ovfIrqEn;
    logic [2:0]        extSync;
    logic              extLvl;
    logic              next_extLvl;
    logic              extRiseQ;
    logic              edgeArmed;
    logic              awHeld;
    logic              wHeld;
    logic [ADDR_W-1:0] awAddr;
    logic [ADDR_W-1:0] rdAddrQ;
    logic [7:0]        wByte;
    logic              wLane;
    logic [7:0]        rdValue;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a == CTRL_OFS) || (a == LOW_OFS) ||
                   (a == HIGH_OFS) || (a == STAT_OFS);
    endfunction : isMapped

    // Bus decode.
    wire awTake  = clkEn & busReq.awvalid & busRsp.awready;
    wire wTake   = clkEn & busReq.wvalid & busRsp.wready;
    wire doWrite = clkEn & awHeld & wHeld & ~busRsp.bvalid;
    wire wrOn    = doWrite & wLane;
    wire wrCtrl  = wrOn & (awAddr == CTRL_OFS);
    wire wrLow   = wrOn & (awAddr == LOW_OFS);
    wire wrHigh  = wrOn & (awAddr == HIGH_OFS);
    wire wrStat  = wrOn & (awAddr == STAT_OFS);
    wire doRead  = clkEn & busReq.arvalid & busRsp.arready;
    wire rdLow   = doRead & (busReq.araddr == LOW_OFS);
    wire bDone   = clkEn & busRsp.bvalid & busReq.bready;
    wire rDone   = clkEn & busRsp.rvalid & busReq.rready;
    wire wide    = ctrl.wideAccessMode;

    // Count source selection.
    wire extSel     = ctrl.clockSourceSelect;
    wire bypass     = extSel & ctrl.extClockSyncBypass;
    wire extRaw     = companionOscEn ? companionOsc : extClockPin;
    wire extRise    = next_extLvl & ~extLvl & edgeArmed;
    wire extFall    = ~next_extLvl & extLvl;
    // The bypassed path skips the alignment flop, so it reacts sooner.
    wire extPulse   = bypass ? extRise : extRiseQ;
    wire srcPulse   = extSel ? extPulse : 1'b1;
    wire presTick;
    wire inc        = presTick & ctrl.counterRun;
    // A bypassed clock cannot be trusted to meet the clear, so it is ignored.
    wire trigOk     = specialTrigger & ~bypass;
    wire cntWrite   = wrLow | (wrHigh & ~wide);
    wire ovfSet     = inc & (count == 16'hffff) & ~cntWrite & ~trigOk;

    stc_prescaler #(
        .W       (PRESCALE_W)
    ) u_prescaler (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .clear   (wrLow),
        .tickIn  (srcPulse & ctrl.counterRun),
        .sel     (ctrl.prescaleSelect),
        .tickOut (presTick)
    );

    assign next_extLvl = (extSync[1] == extSync[2]) ? extSync[2] : extLvl;

    always_comb begin
        next_count = count;
        if (wrLow) begin
            next_count = wide ? {highBuf, wByte}
                              : {count[15:8], wByte};
        end else if (wrHigh && !wide) begin
            next_count = {wByte, count[7:0]};
        end else if (trigOk) begin
            next_count = 16'h0000;
        end else if (inc) begin
            next_count = count + 16'h0001;
        end
    end

    assign next_ctrl = wrCtrl ? stc_ctrl_s'(wByte & CTRL_WMASK)
                              : ctrl;
    // A rollover in the same cycle as a clear keeps the flag set.
    assign next_ovfFlag = ovfSet |
        (ovfFlag & ~(wrStat & wByte[STAT_FLAG_BIT]));
    assign next_ovfIrqEn = wrStat ? wByte[STAT_IEN_BIT] : ovfIrqEn;

    always_comb begin
        case (busReq.araddr)
            CTRL_OFS: rdValue = ctrl & CTRL_WMASK;
            LOW_OFS:  rdValue = count[7:0];
            HIGH_OFS: rdValue = wide ? highBuf : count[15:8];
            STAT_OFS: rdValue = {6'h00, ovfIrqEn, ovfFlag};
            default:  rdValue = 8'h00;
        endcase
    end

    // The first synchroniser flop feeds only the second.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            extSync <= 3'h0;
        end else if (clkEn) begin
            extSync <= {extSync[1:0], extRaw};
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            extLvl    <= 1'b0;
            extRiseQ  <= 1'b0;
            edgeArmed <= 1'b0;
        end else if (clkEn) begin
            extLvl   <= next_extLvl;
            extRiseQ <= extRise;
            if (!(extSel && ctrl.counterRun)) begin
                edgeArmed <= 1'b0;
            end else if (extFall) begin
                edgeArmed <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl        <= stc_ctrl_s'(CTRL_RESET);
            count       <= 16'h0000;
            highBuf     <= 8'h00;
            ovfFlag     <= 1'b0;
            ovfIrqEn    <= 1'b0;
            ccpTimeBase <= 16'h0000;
            overflowIrq <= 1'b0;
        end else if (clkEn) begin
            ctrl     <= next_ctrl;
            count    <= next_count;
            ovfFlag  <= next_ovfFlag;
            ovfIrqEn <= next_ovfIrqEn;
            if (wrHigh && wide) begin
                highBuf <= wByte;
            end else if (rdLow && wide) begin
                highBuf <= count[15:8];
            end
            ccpTimeBase <= next_ctrl.captureTimebaseSelect
                         ? next_count : companionCount;
            overflowIrq <= next_ovfFlag & next_ovfIrqEn;
        end
    end

    // Ready flops cannot drop while frozen, so clkEn must stay high
    // whenever the master has a valid channel pending.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld  <= 1'b0;
            wHeld   <= 1'b0;
            awAddr  <= '0;
            wByte   <= 8'h00;
            wLane   <= 1'b0;
            rdAddrQ <= '0;
            busRsp  <= '0;
        end else if (clkEn) begin
            if (awTake) begin
                awHeld <= 1'b1;
                awAddr <= busReq.awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            if (wTake) begin
                wHeld <= 1'b1;
                wByte <= busReq.wdata[7:0];
                wLane <= busReq.wstrb[0];
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
            busRsp.awready <= ~(awTake | (awHeld & ~doWrite));
            busRsp.wready  <= ~(wTake | (wHeld & ~doWrite));
            if (doWrite) begin
                busRsp.bvalid <= 1'b1;
                busRsp.bresp  <= isMapped(awAddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (bDone) begin
                busRsp.bvalid <= 1'b0;
            end
            if (doRead) begin
                busRsp.arready <= 1'b0;
                busRsp.rvalid  <= 1'b1;
                busRsp.rdata   <= {24'h000000, rdValue};
                busRsp.rresp   <= isMapped(busReq.araddr) ? RESP_OKAY
                                                          : RESP_SLVERR;
                rdAddrQ        <= busReq.araddr;
            end else if (rDone) begin
                busRsp.rvalid  <= 1'b0;
                busRsp.arready <= 1'b1;
            end else if (!busRsp.rvalid) begin
                busRsp.arready <= 1'b1;
            end
        end
    end

    chk_ctrl_bit6: assert property (
        busRsp.rvalid && rdAddrQ == CTRL_OFS |-> busRsp.rdata[6] == 1'b0)
        else $error("control bit 6 read as one");
    chk_stop_holds: assert property (
        clkEn && !ctrl.counterRun && !cntWrite && !trigOk
        |=> $stable(count)) else $error("stopped count moved");
    chk_inc_by_one: assert property (
        clkEn && inc && !cntWrite && !trigOk
        |=> count == $past(count) + 16'h0001)
        else $error("count did not step by one");
    chk_trig_clears: assert property (
        clkEn && trigOk && !cntWrite |=> count == 16'h0000)
        else $error("trigger did not clear count");
    chk_write_wins: assert property (
        clkEn && specialTrigger && wrLow |=> count[7:0] == $past(wByte))
        else $error("trigger overrode count write");
    chk_ovf_sets: assert property (
        clkEn && ovfSet |=> ovfFlag && count == 16'h0000)
        else $error("rollover missed the flag");
    chk_irq_gated: assert property (
        overflowIrq == (ovfFlag && ovfIrqEn))
        else $error("interrupt not gated by enable");
    chk_timebase_route: assert property (
        ctrl.captureTimebaseSelect |-> ccpTimeBase == count)
        else $error("capture time base not this count");
    chk_internal_src: assert property (
        !ctrl.clockSourceSelect |-> srcPulse)
        else $error("internal source not counting every cycle");
    chk_wide_load: assert property (
        rdLow && wide && !wrHigh |=> highBuf == $past(count[15:8]))
        else $error("low read did not buffer high byte");
    chk_wide_write: assert property (
        wrLow && wide |=> count[15:8] == $past(highBuf))
        else $error("low write did not load buffered high");
    chk_first_edge: assert property (
        !edgeArmed |-> !extRise) else $error("edge counted before a fall");
    chk_narrow_high: assert property (
        wrHigh && !wide |=> count == {$past(wByte), $past(count[7:0])})
        else $error("narrow high write missed the count");
    chk_narrow_low: assert property (
        wrLow && !wide |=> count == {$past(count[15:8]), $past(wByte)})
        else $error("narrow low write missed the count");
    chk_low_read: assert property (
        doRead && busReq.araddr == LOW_OFS
        |=> busRsp.rdata[7:0] == $past(count[7:0]))
        else $error("low byte read wrong");
    chk_narrow_read: assert property (
        doRead && busReq.araddr == HIGH_OFS && !wide
        |=> busRsp.rdata[7:0] == $past(count[15:8]))
        else $error("narrow high read not live");
    chk_wide_read: assert property (
        doRead && busReq.araddr == HIGH_OFS && wide
        |=> busRsp.rdata[7:0] == $past(highBuf))
        else $error("wide high read not buffered");
    chk_wide_buffer: assert property (
        wrHigh && wide |=> highBuf == $past(wByte))
        else $error("wide high write missed the buffer");
    // The flag may only rise on a rollover and only fall on a clear.
    chk_ovf_quiet: assert property (
        !ovfFlag && !ovfSet |=> !ovfFlag)
        else $error("flag set without a rollover");
    chk_ovf_holds: assert property (
        ovfFlag && !(wrStat && wByte[STAT_FLAG_BIT]) |=> ovfFlag)
        else $error("flag dropped without a clear");
    chk_irq_needs_en: assert property (
        !ovfIrqEn |-> !overflowIrq)
        else $error("interrupt raised while disabled");
    chk_companion_base: assert property (
        clkEn && !next_ctrl.captureTimebaseSelect
        |=> ccpTimeBase == $past(companionCount))
        else $error("companion count not routed");
    chk_div_one: assert property (
        ctrl.counterRun && !extSel && ctrl.prescaleSelect == PS_DIV1
        |-> inc) else $error("undivided timer skipped a cycle");
    chk_ext_gated: assert property (
        extSel && !extPulse |-> !inc)
        else $error("external count without an edge");
    chk_arm_cleared: assert property (
        clkEn && !(extSel && ctrl.counterRun) |=> !edgeArmed)
        else $error("edge stayed armed while idle");
    // The synchronised path is exactly one flop behind the raw edge.
    chk_sync_delay: assert property (
        clkEn && extSel && !bypass && !wrCtrl && extRise |=> extPulse)
        else $error("synchronised edge lost");
endmodule : stc_timer_counter
`default_nettype wire

/* sim/stc_ccp_model.sv */
// Capture/compare partner and external clock source for the timer bench.
`timescale 1ns/1ps
`default_nettype none
module stc_ccp_model
    import stc_pkg::*;
(
    input  wire logic        sys_clk,         // Bench clock.
    input  wire logic        useOsc,          // Pulse oscillator, not pin.
    output var  logic        extClockPin,     // External count pin.
    output var  logic        companionOsc,    // Companion oscillator.
    output var  logic [15:0] companionCount,  // Companion timer count.
    output var  logic        specialTrigger   // Event trigger to timer.
);
    // Both clock lines idle high, so the first fall arms edge counting.
    initial begin
        extClockPin = 1'b1;
        companionOsc = 1'b1;
        companionCount = 16'hbeef;
        specialTrigger = 1'b0;
    end

    // Each level stands four cycles so the synchroniser sees every edge.
    task automatic pulses(input int n);
        repeat (n) begin
            for (int i = 0; i < 2; i++) begin
                @(posedge sys_clk);
                if (useOsc) begin
                    companionOsc <= i[0];
                end else begin
                    extClockPin <= i[0];
                end
                repeat (3) @(posedge sys_clk);
            end
        end
    endtask : pulses

    task automatic trig();
        @(posedge sys_clk);
        specialTrigger <= 1'b1;
        @(posedge sys_clk);
        specialTrigger <= 1'b0;
    endtask : trig
endmodule : stc_ccp_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the sixteen-bit timer/counter.
`timescale 1ns/1ps
`default_nettype none
module tb
    import stc_pkg::*;
;
    logic         sys_clk;
    logic         nrst;
    logic         oscSel;
    stc_axi_req_s busReq;
    stc_axi_rsp_s busRsp;
    logic         extPin;
    logic         osc;
    logic [15:0]  compCount;
    logic         trigger;
    logic [15:0]  ccpTimeBase;
    logic         overflowIrq;
    logic [31:0]  rdv;
    logic [1:0]   rsp;
    logic [1:0]   wrsp;
    logic [15:0]  cnt;
    int           badCount;
    int           checked;
    int           cyc;

    stc_timer_counter DUT (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1),
        .busReq(busReq), .busRsp(busRsp), .extClockPin(extPin),
        .companionOsc(osc), .companionOscEn(oscSel),
        .companionCount(compCount), .specialTrigger(trigger),
        .ccpTimeBase(ccpTimeBase), .overflowIrq(overflowIrq));

    stc_ccp_model ccp (.sys_clk(sys_clk), .useOsc(oscSel),
        .extClockPin(extPin), .companionOsc(osc),
        .companionCount(compCount), .specialTrigger(trigger));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic end_sim();
        $display("Counts: %0d compares, %0d mismatches", checked, badCount);
        if (badCount == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            badCount++;
            $display("CHECK FAILED at %0t: timeout", $time);
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        checked++;
        if (got !== exp) begin
            badCount++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : chk

    // Handshakes are judged at the falling edge, where ready and valid
    // are settled, and acted on at the following rising edge.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic aw;
        logic w;
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        busReq.awvalid <= 1'b1;
        busReq.awaddr <= a;
        busReq.wvalid <= 1'b1;
        busReq.wdata <= {24'h0, d};
        busReq.wstrb <= 4'hf;
        busReq.bready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk);
            aw = busReq.awvalid && busRsp.awready === 1'b1;
            w = busReq.wvalid && busRsp.wready === 1'b1;
            done = busRsp.bvalid === 1'b1;
            wrsp = busRsp.bresp;
            @(posedge sys_clk);
            if (aw) busReq.awvalid <= 1'b0;
            if (w) busReq.wvalid <= 1'b0;
            if (done) busReq.bready <= 1'b0;
        end
    endtask : wr

    task automatic rd(input logic [3:0] a);
        logic ar;
        logic done;
        done = 1'b0;
        @(posedge sys_clk);
        busReq.arvalid <= 1'b1;
        busReq.araddr <= a;
        busReq.rready <= 1'b1;
        while (!done) begin
            @(negedge sys_clk);
            ar = busReq.arvalid && busRsp.arready === 1'b1;
            done = busRsp.rvalid === 1'b1;
            rdv = busRsp.rdata;
            rsp = busRsp.rresp;
            @(posedge sys_clk);
            if (ar) busReq.arvalid <= 1'b0;
            if (done) busReq.rready <= 1'b0;
        end
    endtask : rd

    task automatic setCount(input logic [15:0] v);
        wr(HIGH_OFS, v[15:8]);
        wr(LOW_OFS, v[7:0]);
    endtask : setCount

    task automatic getCount();
        rd(LOW_OFS);
        cnt[7:0] = rdv[7:0];
        rd(HIGH_OFS);
        cnt[15:8] = rdv[7:0];
    endtask : getCount

    task automatic testReset();
        rd(CTRL_OFS);
        chk(rdv, 32'h0, "control reset");
        wr(CTRL_OFS, 8'hff);
        rd(CTRL_OFS);
        chk(rdv, 32'hbf, "control readback");
        wr(CTRL_OFS, 8'h00);
        chk({30'h0, wrsp}, {30'h0, RESP_OKAY}, "mapped write resp");
        wr(4'h6, 8'h55);
        chk({30'h0, wrsp}, {30'h0, RESP_SLVERR}, "unmapped write resp");
        rd(4'h2);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "unmapped resp");
        $display("reset test done");
    endtask : testReset

    // The run lasts 84 count edges; a bus edge of slack either way.
    task automatic testPrescale();
        int ex;
        logic [15:0] held;
        for (int i = 0; i < 4; i++) begin
            setCount(16'h0000);
            wr(CTRL_OFS, {2'b00, i[1:0], 1'b0, i[0], 2'b01});
            repeat (80) @(posedge sys_clk);
            wr(CTRL_OFS, 8'h00);
            getCount();
            ex = 84 >> i;
            chk({31'h0, cnt >= ex - 1 && cnt <= ex + 1}, 32'h1,
                "prescaled count");
            held = cnt;
            getCount();
            chk({16'h0, cnt}, {16'h0, held}, "stopped count held");
        end
        $display("prescale test done");
    endtask : testPrescale

    task automatic testWide();
        wr(CTRL_OFS, 8'h80);
        wr(HIGH_OFS, 8'h12);
        wr(LOW_OFS, 8'h34);
        wr(CTRL_OFS, 8'h00);
        getCount();
        chk({16'h0, cnt}, 32'h1234, "wide write");
        wr(CTRL_OFS, 8'h80);
        rd(LOW_OFS);
        chk(rdv, 32'h34, "wide low read");
        wr(CTRL_OFS, 8'h00);
        wr(HIGH_OFS, 8'h56);
        wr(CTRL_OFS, 8'h80);
        rd(HIGH_OFS);
        chk(rdv, 32'h12, "buffered high");
        rd(LOW_OFS);
        rd(HIGH_OFS);
        chk(rdv, 32'h56, "narrow high write");
        $display("wide test done");
    endtask : testWide

    task automatic testTimebase();
        wr(CTRL_OFS, 8'h08);
        repeat (2) @(negedge sys_clk);
        chk({16'h0, ccpTimeBase}, 32'h5634, "own time base");
        wr(CTRL_OFS, 8'h00);
        repeat (2) @(negedge sys_clk);
        chk({16'h0, ccpTimeBase}, 32'hbeef, "companion base");
        $display("time base test done");
    endtask : testTimebase

    task automatic testOverflow();
        setCount(16'hfffd);
        wr(CTRL_OFS, 8'h01);
        repeat (10) @(posedge sys_clk);
        wr(CTRL_OFS, 8'h00);
        rd(STAT_OFS);
        chk(rdv, 32'h1, "flag latched");
        chk({31'h0, overflowIrq}, 32'h0, "irq masked");
        wr(STAT_OFS, 8'h02);
        @(negedge sys_clk);
        chk({31'h0, overflowIrq}, 32'h1, "irq enabled");
        wr(STAT_OFS, 8'h03);
        rd(STAT_OFS);
        chk(rdv, 32'h2, "flag cleared");
        chk({31'h0, overflowIrq}, 32'h0, "irq cleared");
        $display("overflow test done");
    endtask : testOverflow

    task automatic testTrigger();
        setCount(16'h4321);
        ccp.trig();
        getCount();
        chk({16'h0, cnt}, 32'h0, "trigger clear");
        setCount(16'h4321);
        // The trigger is sampled at the very edge the low write executes.
        fork
            wr(LOW_OFS, 8'h77);
            begin
                @(posedge sys_clk);
                ccp.trig();
            end
        join
        getCount();
        chk({16'h0, cnt}, 32'h4377, "write beats trigger");
        $display("trigger test done");
    endtask : testTrigger

    // Software keeps bypass away from any clock that feeds the core.
    task automatic testExternal();
        for (int k = 0; k < 3; k++) begin
            oscSel <= k == 2;
            setCount(16'h0000);
            wr(CTRL_OFS, {5'b00000, k == 1, 2'b11});
            ccp.pulses(5);
            repeat (8) @(posedge sys_clk);
            wr(CTRL_OFS, 8'h00);
            getCount();
            chk({16'h0, cnt}, 32'h5, "external edges");
        end
        $display("external test done");
    endtask : testExternal

    initial begin
        nrst = 1'b0;
        oscSel = 1'b0;
        busReq = '0;
        badCount = 0;
        checked = 0;
        cyc = 0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        testReset();
        testPrescale();
        testWide();
        testTimebase();
        testOverflow();
        testTrigger();
        testExternal();
        end_sim();
    end
endmodule : tb
`default_nettype wire
